// >>> design/bis_pkg.sv
// constants, mode codes, search limits and states of the boot image search sequencer
package bis_pkg;
    localparam int unsigned OFS_W          = 15;
    localparam int unsigned ADDR_W         = 32;
    localparam int unsigned STEP_SHIFT     = 15;               // 32 KB between probe locations
    localparam logic [ADDR_W-1:0] STEP_BYTES = 32'h0000_8000;
    localparam logic [OFS_W-1:0]  OFS_RESET  = 15'h0000;
    // boot-mode strap codes
    localparam logic [3:0] MODE_FLASH24    = 4'h1;              // serial_flash_24bit_addr
    localparam logic [3:0] MODE_FLASH32    = 4'h2;              // serial_flash_32bit_addr
    localparam logic [3:0] MODE_SD0        = 4'h3;
    localparam logic [3:0] MODE_NAND       = 4'h4;
    localparam logic [3:0] MODE_SD1        = 4'h5;
    localparam logic [3:0] MODE_EMMC       = 4'h6;
    localparam logic [3:0] MODE_USB        = 4'h7;
    localparam logic [3:0] MODE_SD_LS      = 4'he;
    // search limits, counted in 32 KB steps or in files
    localparam logic [OFS_W:0] LIM_F24_SINGLE = 16'h0200;       // 16 MB
    localparam logic [OFS_W:0] LIM_F24_DUAL   = 16'h0400;       // 32 MB
    localparam logic [OFS_W:0] LIM_F32_SINGLE = 16'h2000;       // 256 MB
    localparam logic [OFS_W:0] LIM_F32_DUAL   = 16'h4000;       // 512 MB
    localparam logic [OFS_W:0] LIM_NAND       = 16'h1000;       // 128 MB
    localparam logic [OFS_W:0] LIM_SD_FILES   = 16'h1fff;       // 8191 files
    localparam logic [OFS_W:0] LIM_NONE       = 16'h0001;       // single attempt, no search
    localparam logic [1:0]     STRAP_SETTLE   = 2'h3;           // edges before the strap is latched

    typedef enum logic [2:0] {
        ST_STRAP   = 3'b000,
        ST_ISSUE   = 3'b001,
        ST_WAIT    = 3'b010,
        ST_LOADED  = 3'b011,
        ST_NEXT    = 3'b100,
        ST_EXHAUST = 3'b101
    } bis_state_e;

    // search limit of a boot device, in offset steps
    function automatic logic [OFS_W:0] bis_limit(input logic [3:0] mode, input logic dual);
        logic [OFS_W:0] lim;
        lim = LIM_NONE;
        case (mode)
            MODE_FLASH24: lim = dual ? LIM_F24_DUAL : LIM_F24_SINGLE;
            MODE_FLASH32: lim = dual ? LIM_F32_DUAL : LIM_F32_SINGLE;
            MODE_NAND:    lim = LIM_NAND;
            MODE_SD0, MODE_SD1, MODE_EMMC, MODE_SD_LS: lim = LIM_SD_FILES;
            default:      lim = LIM_NONE;
        endcase
        return lim;
    endfunction
endpackage

// >>> design/bis_hdr_check.sv
// image identification match and header checksum accumulator
`timescale 1ns/10ps
module bis_hdr_check #(
    parameter int unsigned          HDR_WORDS = 16,
    parameter logic [31:0]          IMAGE_ID  = 32'h5a5a_c3c3 // arbitrary value
) (
    input  wire logic        clk,        // system clock
    input  wire logic        rst,        // synchronous reset
    input  wire logic        clear,      // restart accumulation
    input  wire logic        word_valid, // header word arrives
    input  wire logic [31:0] word_data,  // header word
    input  wire logic [3:0]  word_idx,   // index of the arriving word
    output logic             id_bad,     // word 0 is not the identification value
    output logic             hdr_last,   // arriving word is the checksum word
    output logic             sum_ok      // checksum word matches
);
    logic [31:0] sum_q;

    assign id_bad   = word_valid && (word_idx == 4'h0) && (word_data != IMAGE_ID);
    assign hdr_last = word_valid && (word_idx == 4'(HDR_WORDS - 1));
    assign sum_ok   = (~sum_q) == word_data;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            sum_q <= 32'h0000_0000;
        end else if (word_valid && !hdr_last) begin
            sum_q <= sum_q + word_data;
        end
    end
endmodule

// >>> design/bis_search.sv
// boot image search sequencer: probes 32 KB steps, checks id and header checksum, falls back
// Behaviour
// - the identification value is looked for only at locations 32 KB apart.
// - a matching identification value is followed by a check of the header checksum before acceptance.
// - a correct checksum makes the image at that location the one loaded, so many images share a device.
// - a corrupt image or a failed decryption or authentication adds one to the offset and probes 32 KB on.
// - a missing identification value also adds one to the offset and probes the next 32 KB location.
// - probing and advancing repeat until an image is accepted or the device search limit is reached.
// - software writes the offset and then issues a soft reset, and the search restarts from that offset.
// - the search limit follows the boot device: 16/32 MB, 256/512 MB, NAND 128 MB, SD 8191 files, USB none.
// - the same search and fallback sequence runs in secure and non-secure boot.
// - the boot source is taken from a boot mode register that latches the strap pins at power-on reset.
`timescale 1ns/10ps
module bis_search
    import bis_pkg::*;
#(
    parameter int unsigned HDR_WORDS = 16,
    parameter logic [31:0] IMAGE_ID  = 32'h5a5a_c3c3 // arbitrary value
) (
    input  wire logic                      clk,          // system clock, 200 MHz
    input  wire logic                      rst,          // power-on reset, synchronous
    input  wire logic                      soft_rst,     // soft reset pulse from reset_control_block
    input  wire logic [3:0]                mode_pins,    // boot-mode strap pins
    input  wire logic                      dual_pin,     // strap: dual flash
    input  wire logic                      ofs_wr,       // write the multi-image offset
    input  wire logic [bis_pkg::OFS_W-1:0] ofs_wdata,    // offset to write
    output logic                           rd_req,       // one-cycle read request to boot device
    output logic [bis_pkg::ADDR_W-1:0]     rd_addr,      // byte address of the word read
    input  wire logic                      rd_valid,     // read data valid
    input  wire logic [31:0]               rd_data,      // read data
    input  wire logic                      load_fail,    // loaded image corrupt or failed decrypt/auth
    output logic                           image_found,  // image accepted, level
    output logic                           accept_pulse, // one cycle at acceptance
    output logic [bis_pkg::ADDR_W-1:0]     image_addr,   // address of the accepted image
    output logic                           search_fail,  // limit reached without an image
    output logic                           busy,         // search in progress
    output logic [bis_pkg::OFS_W-1:0]      offset,       // multi-image offset
    output logic [3:0]                     boot_mode     // latched boot mode
);
    import bis_pkg::*;

    bis_state_e          state_q;
    logic [OFS_W-1:0]    offset_q;
    logic [3:0]          wcnt_q;
    logic [1:0]          settle_q;
    logic [3:0]          mode_m_q;
    logic [3:0]          mode_s_q;
    logic                dual_m_q;
    logic                dual_s_q;
    logic [3:0]          mode_q;
    logic                dual_q;
    logic [ADDR_W-1:0]   image_addr_q;
    logic                accept_q;
    logic [OFS_W:0]      limit;
    logic [OFS_W:0]      ofs_next;
    logic                stop;
    logic                out_of_range;
    logic                id_bad;
    logic                hdr_last;
    logic                sum_ok;
    logic                hdr_clear;

    // strap pins come from outside the clock domain
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_m_q <= 4'h0;
            mode_s_q <= 4'h0;
            dual_m_q <= 1'b0;
            dual_s_q <= 1'b0;
        end else begin
            mode_m_q <= mode_pins;
            mode_s_q <= mode_m_q;
            dual_m_q <= dual_pin;
            dual_s_q <= dual_m_q;
        end
    end

    // boot mode register, caught once after power-on reset only
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_q <= 2'h0;
            mode_q   <= 4'h0;
            dual_q   <= 1'b0;
        end else if (state_q == ST_STRAP) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == STRAP_SETTLE) begin
                mode_q <= mode_s_q;
                dual_q <= dual_s_q;
            end
        end
    end

    assign limit        = bis_limit(mode_q, dual_q);
    assign ofs_next     = {1'b0, offset_q} + 16'h0001;
    assign stop         = (mode_q == MODE_USB) || (ofs_next >= limit);
    assign out_of_range = {1'b0, offset_q} >= limit;

    // the flow never looks at secure mode, so both boot methods search alike
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_STRAP;
        end else if (soft_rst && state_q != ST_STRAP) begin
            state_q <= ST_ISSUE;
        end else begin
            unique case (state_q)
                ST_STRAP: begin
                    if (settle_q == STRAP_SETTLE) begin
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_q <= out_of_range ? ST_EXHAUST : ST_WAIT;
                end
                ST_WAIT: begin
                    if (rd_valid) begin
                        if (id_bad) begin
                            state_q <= ST_NEXT;
                        end else if (hdr_last) begin
                            state_q <= sum_ok ? ST_LOADED : ST_NEXT;
                        end else begin
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                ST_LOADED: begin
                    if (load_fail) begin
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    state_q <= stop ? ST_EXHAUST : ST_ISSUE;
                end
                ST_EXHAUST: begin
                    state_q <= ST_EXHAUST;
                end
                default: begin
                    state_q <= ST_STRAP;
                end
            endcase
        end
    end

    // multi-image offset: cleared by power-on reset only
    always_ff @(posedge clk) begin
        if (rst) begin
            offset_q <= OFS_RESET;
        end else if (ofs_wr) begin
            offset_q <= ofs_wdata;
        end else if (state_q == ST_NEXT && !stop) begin
            offset_q <= ofs_next[OFS_W-1:0];
        end
    end

    // header word index within the current candidate
    always_ff @(posedge clk) begin
        if (rst || soft_rst || state_q == ST_NEXT) begin
            wcnt_q <= 4'h0;
        end else if (state_q == ST_WAIT && rd_valid) begin
            wcnt_q <= wcnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            image_addr_q <= 32'h0000_0000;
            accept_q     <= 1'b0;
        end else begin
            // a soft reset in the checksum cycle restarts the search, so no acceptance is reported
            accept_q <= state_q == ST_WAIT && rd_valid && hdr_last && !id_bad && sum_ok && !soft_rst;
            if (state_q == ST_WAIT && rd_valid && hdr_last && !id_bad && sum_ok && !soft_rst) begin
                image_addr_q <= {2'b00, offset_q, 15'h0000};
            end
        end
    end

    assign hdr_clear = (state_q != ST_ISSUE) && (state_q != ST_WAIT);

    bis_hdr_check #(
        .HDR_WORDS (HDR_WORDS),
        .IMAGE_ID  (IMAGE_ID)
    ) u_hdr (
        .clk        (clk),
        .rst        (rst),
        .clear      (hdr_clear || soft_rst),
        .word_valid (state_q == ST_WAIT && rd_valid),
        .word_data  (rd_data),
        .word_idx   (wcnt_q),
        .id_bad     (id_bad),
        .hdr_last   (hdr_last),
        .sum_ok     (sum_ok)
    );

    // probe base is offset times 32 KB, header words follow it
    assign rd_req       = (state_q == ST_ISSUE) && !out_of_range && !soft_rst;
    assign rd_addr      = {2'b00, offset_q, 15'h0000} | {26'h0000000, wcnt_q, 2'b00};
    assign image_found  = state_q == ST_LOADED;
    assign accept_pulse = accept_q;
    assign image_addr   = image_addr_q;
    assign search_fail  = state_q == ST_EXHAUST;
    assign busy         = (state_q != ST_LOADED) && (state_q != ST_EXHAUST);
    assign offset       = offset_q;
    assign boot_mode    = mode_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_probe_align: assert property (rd_req && wcnt_q == 4'h0 |-> rd_addr[14:0] == 15'h0000)
        else $error("probe not on a 32 KB boundary");
    a_probe_offset: assert property (rd_req |-> rd_addr[31:15] == {2'b00, offset_q})
        else $error("probe address does not follow the offset");
    a_accept_checksum: assert property (accept_pulse |-> $past(sum_ok) && $past(hdr_last) && !$past(id_bad))
        else $error("image accepted without a good checksum");
    a_accept_loads: assert property (accept_pulse
        |-> image_found && image_addr == {2'b00, $past(offset_q), 15'h0000})
        else $error("accepted image not reported at its probe address");
    a_fail_advance: assert property (state_q == ST_LOADED && load_fail && !soft_rst ##1 !stop && !ofs_wr
        |=> offset_q == $past(offset_q) + 15'h0001)
        else $error("load failure did not advance the offset");
    a_miss_advance: assert property (state_q == ST_WAIT && rd_valid && id_bad && !soft_rst
        |=> state_q == ST_NEXT ##1 (stop || $past(ofs_wr) || offset_q == $past(offset_q) + 15'h0001))
        else $error("missing identification did not advance");
    a_limit_stop: assert property (state_q == ST_NEXT && stop && !soft_rst |=> search_fail)
        else $error("limit reached but search did not stop");
    a_limit_nand: assert property (boot_mode == MODE_NAND |-> limit == LIM_NAND)
        else $error("wrong search limit for nand");
    a_soft_restart: assert property (soft_rst && state_q != ST_STRAP |=> state_q == ST_ISSUE && wcnt_q == 4'h0)
        else $error("soft reset did not restart the search");
    a_mode_held: assert property (state_q != ST_STRAP |=> $stable(boot_mode))
        else $error("boot mode changed after it was latched");
    a_ofs_kept: assert property (soft_rst && !ofs_wr && state_q != ST_NEXT |=> $stable(offset_q))
        else $error("soft reset disturbed the offset");
endmodule

// >>> verification/bis_flash_model.sv
// behavioural boot flash holding header images at 32 KB steps
`timescale 1ns/10ps
module bis_flash_model #(
    parameter logic [31:0] IMAGE_ID = 32'h1d3a_77e5 // arbitrary value
) (
    input  wire logic        clk,      // system clock
    input  wire logic        rd_req,   // read request from the searcher
    input  wire logic [31:0] rd_addr,  // byte address of the word
    input  wire logic [15:0] good_map, // offsets holding a sound image
    input  wire logic [15:0] bad_map,  // offsets holding a header with a broken checksum
    input  wire logic        slow,     // answer after extra wait cycles
    output logic             rd_valid, // word returned
    output logic [31:0]      rd_data   // returned word
);
    logic        pend_q  = 1'b0;
    logic        valid_q = 1'b0;
    logic [2:0]  wait_q  = 3'h0;
    logic [31:0] addr_q  = 32'h0000_0000;
    logic [31:0] data_q  = 32'h0000_0000;

    function automatic logic [31:0] body_word(input logic [3:0] ofs, input logic [3:0] idx);
        return (idx == 4'h0) ? IMAGE_ID : (32'h6e00_0000 | {20'h0_0000, ofs, 4'h0, idx});
    endfunction

    function automatic logic [31:0] flash_word(input logic [31:0] a);
        logic [3:0]  ofs;
        logic [31:0] sum;
        ofs = a[18:15];
        sum = 32'h0000_0000;
        if (a[31:19] != 13'h0000 || !(good_map[ofs] || bad_map[ofs])) return 32'hffff_ffff; // erased
        if (a[5:2] != 4'hf) return body_word(ofs, a[5:2]);
        for (int i = 0; i < 15; i++) sum = sum + body_word(ofs, i[3:0]);
        return bad_map[ofs] ? sum : ~sum; // a broken header carries the plain sum
    endfunction

    always_ff @(posedge clk) begin
        if (rd_req) begin
            pend_q <= 1'b1;
            addr_q <= rd_addr;
            wait_q <= slow ? 3'h4 : 3'h0;
        end else if (pend_q && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
        end
    end

    // answer one cycle after the wait count runs out; no stale word once the answer has gone
    always_ff @(posedge clk) begin
        valid_q <= !rd_req && pend_q && wait_q == 3'h0;
        data_q  <= (!rd_req && pend_q && wait_q == 3'h0) ? flash_word(addr_q) : ~data_q;
    end
    assign rd_valid = valid_q;
    assign rd_data  = data_q;
endmodule

// >>> verification/tb.sv
// self-checking testbench of the boot image search sequencer
`timescale 1ns/10ps
module tb;
    import bis_pkg::*;
    localparam logic [31:0] ID = 32'h1d3a_77e5; // arbitrary value
    logic             clk       = 1'b0;
    logic             rst       = 1'b1;
    logic             soft_rst  = 1'b0;
    logic [3:0]       mode_pins = 4'h1;
    logic             dual_pin  = 1'b0;
    logic             ofs_wr    = 1'b0;
    logic [OFS_W-1:0] ofs_wdata = 15'h0000;
    logic             load_fail = 1'b0;
    logic             slow      = 1'b0;
    logic [15:0]      good_map  = 16'h0001;
    logic [15:0]      bad_map   = 16'h0000;
    logic             rd_req, rd_valid, image_found, accept_pulse, search_fail, busy;
    logic [31:0]      rd_addr, rd_data, image_addr;
    logic [OFS_W-1:0] offset;
    logic [3:0]       boot_mode;
    int               error_cnt = 0;
    int               n_tests   = 0;
    int               n_reads   = 0;
    int               n_acc     = 0;
    int               cyc       = 0;
    int               exp_idx   = 0;

    bis_search #(.HDR_WORDS(16), .IMAGE_ID(ID)) u_bis_search (.clk, .rst, .soft_rst, .mode_pins, .dual_pin,
        .ofs_wr, .ofs_wdata, .rd_req, .rd_addr, .rd_valid, .rd_data, .load_fail, .image_found, .accept_pulse,
        .image_addr, .search_fail, .busy, .offset, .boot_mode);
    bis_flash_model #(.IMAGE_ID(ID)) u_bis_flash_model (.clk, .rd_req, .rd_addr, .good_map, .bad_map, .slow,
        .rd_valid, .rd_data);

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_flag(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read monitor: every probe word sits inside the 32 KB slot of the current offset
    always @(posedge clk) begin
        cyc++;
        if (accept_pulse === 1'b1) n_acc++;
        if (rd_req === 1'b1) begin
            n_reads++;
            chk_val("rd_addr", {2'b00, offset, 15'h0000} | (exp_idx << 2), rd_addr);
        end
        // next header word: back to word 0 after a wrong id or after the checksum word
        if (rd_valid === 1'b1) begin
            exp_idx = (exp_idx == 15 || (exp_idx == 0 && rd_data !== ID)) ? 0 : exp_idx + 1;
        end
        if (cyc == 90000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic por(input logic [3:0] m, input logic d);
        @(posedge clk);
        rst       <= 1'b1;
        mode_pins <= m;
        dual_pin  <= d;
        repeat (4) @(posedge clk);
        rst     <= 1'b0;
        n_reads = 0;
        n_acc   = 0;
    endtask

    task automatic pulse_soft();
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        n_reads  = 0;
        n_acc    = 0;
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        repeat (3) @(posedge clk);
        while (image_found !== 1'b1 && search_fail !== 1'b1 && i < 60000) begin
            @(posedge clk);
            i++;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic t_first();
        por(MODE_FLASH24, 1'b0);
        chk_val("offset", 32'h0, {17'h0, offset});
        chk_flag("busy", 1'b1, busy);
        wait_done();
        chk_flag("image_found", 1'b1, image_found);
        chk_flag("busy", 1'b0, busy);
        chk_val("image_addr", 32'h0, image_addr);
        chk_val("boot_mode", {28'h0, MODE_FLASH24}, {28'h0, boot_mode});
        chk_val("reads", 32'd16, n_reads);
        chk_val("accepts", 32'd1, n_acc);
        $display("test first_image done");
    endtask

    task automatic t_fallback();
        good_map <= 16'h0011;
        bad_map  <= 16'h0002;
        slow     <= 1'b1;
        n_reads  = 0;
        n_acc    = 0;
        @(posedge clk);
        load_fail <= 1'b1;
        @(posedge clk);
        load_fail <= 1'b0;
        wait_done();
        chk_val("image_addr", 32'h0002_0000, image_addr);
        chk_val("offset", 32'h4, {17'h0, offset});
        chk_val("reads", 32'd34, n_reads);
        chk_val("accepts", 32'd1, n_acc);
        chk_flag("search_fail", 1'b0, search_fail);
        $display("test fallback done");
    endtask

    task automatic t_soft_select();
        slow      <= 1'b0;
        bad_map   <= 16'h0000;
        mode_pins <= MODE_NAND;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ofs_wr    <= 1'b1;
            ofs_wdata <= 15'(k * 4);
            @(posedge clk);
            ofs_wr <= 1'b0;
            pulse_soft();
            wait_done();
            chk_val("image_addr", 32'(k * 4) << 15, image_addr);
            chk_val("reads", 32'd16, n_reads);
            chk_val("boot_mode", {28'h0, MODE_FLASH24}, {28'h0, boot_mode});
        end
        $display("test soft_select done");
    endtask

    task automatic t_limits();
        logic [3:0] m[5]   = '{MODE_FLASH24, MODE_FLASH24, MODE_NAND, MODE_SD1, MODE_USB};
        logic       d[5]   = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        int         lim[5] = '{512, 1024, 4096, 8191, 1};
        good_map <= 16'h0000;
        for (int k = 0; k < 5; k++) begin
            por(m[k], d[k]);
            chk_val("offset", 32'h0, {17'h0, offset});
            wait_done();
            chk_flag("search_fail", 1'b1, search_fail);
            chk_flag("busy", 1'b0, busy);
            chk_val("reads", lim[k], n_reads);
            chk_val("offset", lim[k] - 1, {17'h0, offset});
            pulse_soft();
            wait_done();
            chk_val("reads", 32'd1, n_reads);
        end
        $display("test limits done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        t_first();
        t_fallback();
        t_soft_select();
        t_limits();
        end_of_test();
    end
endmodule
